// file: include/vad_map.svh
// Offsets, reset values and limits of the voice activity decision block.
`ifndef VAD_MAP_SVH
`define VAD_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VAD_OFS_CTRL        8'h00
`define VAD_OFS_STATUS      8'h04
`define VAD_OFS_THRESH      8'h08
`define VAD_OFS_FRAMES      8'h0C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define VAD_CTRL_ADAPT_BIT  0
`define VAD_CTRL_RST        32'h0000_0001
`define VAD_ST_RAW_BIT      0
`define VAD_ST_HOLD_BIT     1
`define VAD_ST_TONE_BIT     2
`define VAD_ST_PER_BIT      3
`define VAD_ST_RUN_LSB      8
`define VAD_ST_HCNT_LSB     16
`define VAD_ST_QUIET_LSB    24

// ----------------------------------------------------------------------------
// Energies: linear limits and pseudo-float reset values
// ----------------------------------------------------------------------------
`define VAD_LOW_ENERGY_LIN  64'h0000_0000_0001_FBD0
`define VAD_MARGIN_LIN      64'h0000_0000_0421_F15C
`define VAD_FLOOR_E         16'h0013
`define VAD_FLOOR_M         16'h54A3
`define VAD_THR_RST_E       16'h0014
`define VAD_THR_RST_M       16'h69CB
`define VAD_MANT_MIN        16'h4000
`define VAD_MANT_SHIFT      15
`define VAD_FAC_NUM         64'h0000_0000_0000_0015
`define VAD_FAC_DEN         64'h0000_0000_0000_000A
`define VAD_FALL_SHIFT      5
`define VAD_RISE_SHIFT      4

// ----------------------------------------------------------------------------
// Tone detection limits in Q15
// ----------------------------------------------------------------------------
`define VAD_Q15_ONE         34'h0_0000_8000
`define VAD_PRED_ERR_LIMIT  34'h0_0000_05B9
`define VAD_POLE_LIMIT      16'h0C74

// ----------------------------------------------------------------------------
// Counters, autocorrelation and pitch
// ----------------------------------------------------------------------------
`define VAD_MIN_RUN         3
`define VAD_HOLD_FRAMES     10
`define VAD_ADAPT_LIMIT     8
`define VAD_RVAD0_RST       16'h0006
`define VAD_LAG_RST         8'h12
`define VAD_LAG_CLOSE       8'h02
`define VAD_LAG_MATCH_LIM   4'h4

`endif

// file: include/vad_pkg.sv
// Types shared by the voice activity decision block.
package vad_pkg;

    typedef struct packed {
        logic signed [15:0] e;
        logic        [15:0] m;
    } pfloat_t;

    typedef struct packed {
        pfloat_t                  acf0;
        pfloat_t                  pvad;
        logic signed [3:0][15:0]  refl_coef;
        logic                     stat;
    } frame_in_t;

    typedef struct packed {
        logic [7:0] lag1;
        logic [7:0] lag2;
    } lags_t;

endpackage : vad_pkg

// file: rtl/voice_activity_decision.sv
// Per-frame voice activity decision with threshold adaptation and hangover.
`include "vad_map.svh"

module voice_activity_decision
    import vad_pkg::*;
#(
    parameter int MIN_RUN     = `VAD_MIN_RUN,
    parameter int HOLD_FRAMES = `VAD_HOLD_FRAMES,
    parameter int ADAPT_LIMIT = `VAD_ADAPT_LIMIT
) (
    input  wire logic                   hclk,          // Bus and block clock
    input  wire logic                   hresetn,       // Async reset, low
    input  wire logic                   hsel,          // Slave select
    input  wire logic [7:0]             haddr,         // Byte address
    input  wire logic [1:0]             htrans,        // Transfer type
    input  wire logic                   hwrite,        // Write access
    input  wire logic [2:0]             hsize,         // Transfer size
    input  wire logic [31:0]            hwdata,        // Write data
    input  wire logic                   hready,        // Bus ready in
    output logic      [31:0]            hrdata,        // Read data
    output logic                        hreadyout,     // Slave ready
    output logic                        hresp,         // Always OKAY
    input  wire logic                   frame_valid,   // Frame data strobe
    input  wire frame_in_t              frame_in,      // Encoder frame data
    input  wire logic [8:0][15:0]       avg_pred_ac,   // Averaged predictor AC
    input  wire logic                   lag_valid,     // Pitch lag strobe
    input  wire lags_t                  lags_in,       // Two open-loop lags
    output logic                        decision_valid,// Decision pulse
    output logic                        speech_flag,   // Decision with hold
    output logic                        raw_flag,      // Decision before hold
    output logic                        tone_flag,     // Information tone
    output logic                        periodic_flag, // Periodicity
    output logic [8:0][15:0]            filter_ac      // Adaptive filter AC
);

    // ------------------------------------------------------------------------
    // Parameter checks and helpers
    // ------------------------------------------------------------------------
    initial begin
        if (MIN_RUN < 1 || MIN_RUN > 7 || HOLD_FRAMES < 0 ||
            HOLD_FRAMES > 30 || ADAPT_LIMIT < 1 || ADAPT_LIMIT > 255) begin
            $error("voice_activity_decision: unsupported parameters");
        end
    end

    localparam logic [2:0] RUN_MAX  = 3'(MIN_RUN);
    localparam logic signed [5:0] HOLD_LD = 6'(HOLD_FRAMES);
    localparam logic [7:0] QUIET_MAX = 8'(ADAPT_LIMIT);

    // A pseudo-float value turned into a plain integer; fractions drop out.
    function automatic logic [63:0] pf_lin(input pfloat_t v);
        logic [63:0] x;
        x = 64'(v.m);
        if (v.e < 0 || v.e > 47) begin
            x = '0;
        end else begin
            x = (x << v.e[5:0]) >> `VAD_MANT_SHIFT;
        end
        return x;
    endfunction : pf_lin

    // Normalise so that the mantissa sits at 16384 or above.
    function automatic pfloat_t pf_norm(input logic [63:0] x);
        pfloat_t r;
        int      p;
        p = 0;
        for (int i = 0; i < 64; i++) begin
            if (x[i]) begin
                p = i;
            end
        end
        if (x == '0) begin
            r.e = '0;
            r.m = `VAD_MANT_MIN;
        end else if (p >= 14) begin
            r.e = 16'(p + 1);
            r.m = 16'(x >> (p - 14));
        end else begin
            r.e = 16'(p + 1);
            r.m = 16'(x << (14 - p));
        end
        return r;
    endfunction : pf_norm

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    pfloat_t             thr_r;
    pfloat_t             thr_nxt;
    logic [7:0]          quiet_r;
    logic [7:0]          quiet_nxt;
    logic [2:0]          run_r;
    logic [2:0]          run_nxt;
    logic signed [5:0]   hold_r;
    logic signed [5:0]   hold_nxt;
    logic [3:0]          old_cnt_r;
    logic [3:0]          vold_cnt_r;
    logic [7:0]          lag0_r;
    logic [31:0]         ctrl_r;
    logic [31:0]         frames_r;
    logic [63:0]         pvad_lin_r;
    logic                tone_nxt;
    logic                raw_nxt;
    logic                upd_ac;
    logic                quiet_case;
    logic                low_energy;
    logic signed [35:0]  im_q30;
    logic signed [16:0]  a1;

    // ------------------------------------------------------------------------
    // Tone detection
    // ------------------------------------------------------------------------
    always_comb begin
        logic [33:0]        err;
        logic signed [31:0] sq;
        logic [35:0]        a1sq;
        logic               pole_low;
        err = `VAD_Q15_ONE;
        sq  = '0;
        for (int i = 0; i < 4; i++) begin
            // Packed elements read back unsigned, so sign them explicitly.
            sq  = 32'($signed(frame_in.refl_coef[i]) *
                      $signed(frame_in.refl_coef[i])) >>> 15;
            err = 34'((err * (`VAD_Q15_ONE - 34'(sq))) >> 15);
        end
        // Second-order step-up: a1 = rc1 (1 + rc2), a2 = rc2.
        a1 = 17'($signed(frame_in.refl_coef[0])) +
             17'((32'($signed(frame_in.refl_coef[0])) *
                  32'($signed(frame_in.refl_coef[1]))) >>> 15);
        a1sq   = 36'(a1 * a1);
        im_q30 = (36'($signed(frame_in.refl_coef[1])) <<< 17) -
                 $signed(a1sq);
        // The scaled products need 64 bits; 36 would wrap for large terms.
        pole_low = !im_q30[35] && a1[16] &&
            (64'(im_q30) * 64'sd32768 <
             $signed(64'(a1sq) * 64'(`VAD_POLE_LIMIT)));
        tone_nxt = !im_q30[35] && !pole_low &&
                   (err < `VAD_PRED_ERR_LIMIT);
    end

    // ------------------------------------------------------------------------
    // Threshold adaptation and raw decision
    // ------------------------------------------------------------------------
    always_comb begin
        logic [63:0] t;
        logic [63:0] pv;
        logic [63:0] td;
        logic [63:0] tu;
        logic [63:0] pf;
        logic [63:0] nt;
        t   = pf_lin(thr_r);
        pv  = pf_lin(frame_in.pvad);
        td  = t - (t >> `VAD_FALL_SHIFT);
        tu  = t + (t >> `VAD_RISE_SHIFT);
        pf  = (pv * `VAD_FAC_NUM) / `VAD_FAC_DEN;
        nt  = t;
        low_energy = pf_lin(frame_in.acf0) < `VAD_LOW_ENERGY_LIN;
        quiet_case = frame_in.stat && !periodic_flag && !tone_nxt &&
                     ctrl_r[`VAD_CTRL_ADAPT_BIT];
        quiet_nxt  = quiet_r;
        upd_ac     = 1'b0;
        thr_nxt    = thr_r;
        if (low_energy) begin
            thr_nxt.e = `VAD_FLOOR_E;
            thr_nxt.m = `VAD_FLOOR_M;
        end else if (!quiet_case) begin
            quiet_nxt = '0;
        end else begin
            quiet_nxt = (quiet_r >= QUIET_MAX) ? QUIET_MAX : quiet_r + 8'd1;
            if (quiet_nxt >= QUIET_MAX) begin
                upd_ac = 1'b1;
                if (td >= pf) begin
                    nt = td;
                end else begin
                    nt = (tu < pf) ? tu : pf;
                end
                if (nt > pv + `VAD_MARGIN_LIN) begin
                    nt = pv + `VAD_MARGIN_LIN;
                end
                thr_nxt = pf_norm(nt);
            end
        end
        raw_nxt = pv > pf_lin(thr_nxt);
    end

    // ------------------------------------------------------------------------
    // Hangover
    // ------------------------------------------------------------------------
    always_comb begin
        logic [2:0] run_inc;
        run_inc  = raw_nxt ? run_r + 3'd1 : '0;
        run_nxt  = run_inc;
        hold_nxt = hold_r;
        if (run_inc >= RUN_MAX) begin
            run_nxt  = RUN_MAX;
            hold_nxt = HOLD_LD;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr_r.e <= `VAD_THR_RST_E;
            thr_r.m <= `VAD_THR_RST_M;
            quiet_r <= '0;
        end else if (frame_valid) begin
            thr_r   <= thr_nxt;
            quiet_r <= quiet_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filter_ac <= '0;
            filter_ac[0] <= `VAD_RVAD0_RST;
        end else if (frame_valid && upd_ac) begin
            filter_ac <= avg_pred_ac;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r          <= '0;
            hold_r         <= -6'sd1;
            speech_flag    <= 1'b0;
            raw_flag       <= 1'b0;
            tone_flag      <= 1'b0;
            decision_valid <= 1'b0;
            pvad_lin_r     <= '0;
            frames_r       <= '0;
        end else begin
            decision_valid <= frame_valid;
            if (frame_valid) begin
                run_r       <= run_nxt;
                raw_flag    <= raw_nxt;
                tone_flag   <= tone_nxt;
                speech_flag <= raw_nxt || (hold_nxt >= 0);
                hold_r      <= (hold_nxt >= 0) ? hold_nxt - 6'sd1 : hold_nxt;
                pvad_lin_r  <= pf_lin(frame_in.pvad);
                frames_r    <= frames_r + 32'd1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Periodicity from pitch lags
    // ------------------------------------------------------------------------
    // The lag strobe follows the decision, so the flag serves the next frame.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periodic_flag <= 1'b1;
            old_cnt_r     <= '0;
            vold_cnt_r    <= '0;
            lag0_r        <= `VAD_LAG_RST;
        end else if (lag_valid) begin
            logic [3:0] cnt;
            cnt = 4'(((lag0_r > lags_in.lag1 ? lag0_r - lags_in.lag1 :
                      lags_in.lag1 - lag0_r) < `VAD_LAG_CLOSE)) +
                  4'(((lags_in.lag1 > lags_in.lag2 ?
                      lags_in.lag1 - lags_in.lag2 :
                      lags_in.lag2 - lags_in.lag1) < `VAD_LAG_CLOSE));
            periodic_flag <= (old_cnt_r + vold_cnt_r) >=
                             `VAD_LAG_MATCH_LIM;
            vold_cnt_r    <= old_cnt_r;
            old_cnt_r     <= cnt;
            lag0_r        <= lags_in.lag2;
        end
    end

    // ------------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------------
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        take;
    logic [31:0] rd_val;
    assign take = hsel && htrans[1] && hready;

    always_comb begin
        rd_val = '0;
        unique case (haddr)
            `VAD_OFS_CTRL:   rd_val = ctrl_r;
            `VAD_OFS_STATUS: begin
                rd_val[`VAD_ST_RAW_BIT]  = raw_flag;
                rd_val[`VAD_ST_HOLD_BIT] = speech_flag;
                rd_val[`VAD_ST_TONE_BIT] = tone_flag;
                rd_val[`VAD_ST_PER_BIT]  = periodic_flag;
                rd_val[`VAD_ST_RUN_LSB +: 3]   = run_r;
                rd_val[`VAD_ST_HCNT_LSB +: 6]  = hold_r;
                rd_val[`VAD_ST_QUIET_LSB +: 8] = quiet_r;
            end
            `VAD_OFS_THRESH: rd_val = {thr_r.e, thr_r.m};
            `VAD_OFS_FRAMES: rd_val = frames_r;
            default:         rd_val = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr;
            if (take && !hwrite) begin
                hrdata <= rd_val;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `VAD_CTRL_RST;
        end else if (wr_pend_r && wr_addr_r == `VAD_OFS_CTRL) begin
            ctrl_r <= {31'd0, hwdata[`VAD_CTRL_ADAPT_BIT]};
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence seq_long_burst;
        frame_valid && raw_nxt && run_r >= RUN_MAX - 3'd1;
    endsequence

    chk_floor_load: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_valid && low_energy |=> thr_r.e == `VAD_FLOOR_E &&
        thr_r.m == `VAD_FLOOR_M && $stable(filter_ac))
        else $error("threshold not forced to floor on low energy");

    chk_margin_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
        decision_valid && !$past(low_energy) |->
        pf_lin(thr_r) <= pvad_lin_r + `VAD_MARGIN_LIN)
        else $error("threshold above energy plus margin");

    chk_raw_strict: assert property (@(posedge hclk) disable iff (!hresetn)
        decision_valid |-> raw_flag == (pvad_lin_r > pf_lin(thr_r)))
        else $error("raw decision disagrees with threshold");

    chk_run_saturate: assert property (@(posedge hclk) disable iff (!hresetn)
        run_r <= RUN_MAX)
        else $error("speech run counter above limit");

    chk_hold_load: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_long_burst |=> hold_r == HOLD_LD - 6'sd1 && speech_flag)
        else $error("hold not loaded after long burst");

    chk_hold_output: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_valid && !raw_nxt && run_r < RUN_MAX && hold_r >= 0 |=>
        speech_flag && hold_r == $past(hold_r) - 6'sd1)
        else $error("hangover output or decrement wrong");

    chk_periodic_block: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_valid && periodic_flag && !low_energy |=>
        $stable(thr_r) && $stable(filter_ac) && quiet_r == 8'd0)
        else $error("adaptation while periodic");

    chk_adapt_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_valid && !low_energy && quiet_r < QUIET_MAX - 8'd1 |=>
        $stable(thr_r) && $stable(filter_ac))
        else $error("adaptation before enough quiet frames");

    chk_pole_noise: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_valid && im_q30 < 0 |=> !tone_flag)
        else $error("tone flagged with real poles");

    chk_lag_periodic: assert property (@(posedge hclk) disable iff (!hresetn)
        lag_valid |=> periodic_flag ==
        (($past(old_cnt_r) + $past(vold_cnt_r)) >= `VAD_LAG_MATCH_LIM))
        else $error("periodic flag not from two match counts");

endmodule : voice_activity_decision

// file: testbench/encoder_model.sv
// Encoder stand-in that hands the block one frame and then its lags.
module encoder_model
    import vad_pkg::*;
(
    input  wire logic      hclk,        // Block clock
    input  wire logic      hresetn,     // Async reset, low
    input  wire logic      send,        // Deliver one frame
    input  wire frame_in_t fin,         // Frame contents
    input  wire lags_t     lin,         // Lags of that frame
    output logic           frame_valid, // Frame strobe
    output frame_in_t      frame_in,    // Frame data
    output logic           lag_valid,   // Lag strobe
    output lags_t          lags_in      // Lag data
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_valid <= 1'b0;
            lag_valid   <= 1'b0;
            frame_in    <= '0;
            lags_in     <= '0;
        end else begin
            // Idle data toggles so that a sample one cycle late never sees a match.
            frame_valid <= send;
            frame_in    <= send ? fin : ~frame_in;
            lag_valid   <= frame_valid;
            lags_in     <= frame_valid ? lin : ~lags_in;
        end
    end
endmodule : encoder_model

// file: testbench/tb.sv
// Self-checking bench of the voice activity decision block.
`include "vad_map.svh"
module tb
    import vad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic             hwrite = 1'b0, send = 1'b0;
    logic [7:0]       haddr = 8'h00;
    logic [1:0]       htrans = 2'b00;
    logic [2:0]       hsize = 3'b010;
    logic [31:0]      hwdata = 32'h0000_0000, hrdata, q;
    logic [31:0]      seed = 32'd66363;
    logic             hready, hreadyout, hresp, frame_valid, lag_valid;
    logic             dvalid, speech, raw, tone, ptch, eb;
    logic [8:0][15:0] apa = '0, fac;
    frame_in_t        fin = '0, frame_in;
    lags_t            lin = '0, lags_in;
    int               n_errors = 0, check_count = 0;
    int               run = 0, hold = -1, old = 0, vold = 0, lag0 = 18;
    real              t0, t1;
    always #4 hclk = ~hclk;
    assign hready = hreadyout;
    voice_activity_decision dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .frame_valid(frame_valid), .frame_in(frame_in),
        .avg_pred_ac(apa), .lag_valid(lag_valid), .lags_in(lags_in),
        .decision_valid(dvalid), .speech_flag(speech), .raw_flag(raw),
        .tone_flag(tone), .periodic_flag(ptch), .filter_ac(fac));
    encoder_model enc_u (
        .hclk(hclk), .hresetn(hresetn), .send(send), .fin(fin), .lin(lin),
        .frame_valid(frame_valid), .frame_in(frame_in),
        .lag_valid(lag_valid), .lags_in(lags_in));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic real pf(input logic [31:0] v);
        return v[15:0] * (2.0 ** $signed(v[31:16])) / 32768.0;
    endfunction : pf
    task automatic check(input string nm, input logic [143:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // One AHB single transfer; waits on hready in both phases.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        check("hresp", hresp, 1'b0);
    endtask : bus
    // Sends a frame, predicts hangover and periodicity, checks both.
    task automatic frame(input logic [63:0] ap, input logic st, er,
                         input int l1, l2);
        int n;
        logic ep;
        fin  <= {ap, 64'h0, st};
        lin  <= {l1[7:0], l2[7:0]};
        send <= 1'b1;
        @(posedge hclk);
        send <= 1'b0;
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (dvalid !== 1'b1 && n < 8);
        run = er ? run + 1 : 0;
        if (run >= 3) begin
            hold = 10;
            run  = 3;
        end
        check("latency", n, 1);
        check("raw", raw, er);
        check("speech", speech, er || hold >= 0);
        check("tone", tone, 1'b0);
        if (hold >= 0)
            hold--;
        ep   = (old + vold) >= 4;
        vold = old;
        old  = int'((lag0 - l1) * (lag0 - l1) < 4) + int'((l1 - l2) ** 2 < 4);
        lag0 = l2;
        @(posedge hclk);
        #1;
        check("periodic", ptch, ep);
        @(posedge hclk);
    endtask : frame
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, `VAD_OFS_STATUS, 0);
        check("status", q, 32'h003F_0008);
        bus(1, `VAD_OFS_THRESH, 32'hFFFF_FFFF);
        bus(0, `VAD_OFS_THRESH, 0);
        check("thr", q, {`VAD_THR_RST_E, `VAD_THR_RST_M});
        check("ac", fac, {128'h0, 16'h0006});
        bus(1, `VAD_OFS_CTRL, 0);
        bus(0, `VAD_OFS_CTRL, 0);
        check("ctrl", q, 0);
        bus(1, `VAD_OFS_CTRL, `VAD_CTRL_RST);
        bus(0, 8'h40, 0);
        check("unmapped", q, 0);
        // Fixed burst pattern first, then random decisions; lags are random throughout.
        for (int i = 0; i < 57; i++) begin
            seed = lfsr(seed);
            // Energy one above the threshold exactly when speech is wanted.
            eb = i < 17 ? 1'(17'h0_003B >> i) : seed[0];
            frame({32'h0014_4000, 16'h0014, 16'h69CB + 16'(eb)}, 0, eb,
                  20 + int'(seed[2:1]), 20 + int'(seed[4:3]));
        end
        frame({32'h0010_4000, 32'h0010_4000}, 0, 0, 20, 60);
        bus(0, `VAD_OFS_THRESH, 0);
        check("floor", q, {`VAD_FLOOR_E, `VAD_FLOOR_M});
        check("ac kept", fac, {128'h0, 16'h0006});
        frame({32'h0014_4000, 32'h0010_4000}, 0, 0, 60, 90);
        apa <= {seed, ~seed, seed, ~seed, seed[15:0]};
        t0 = pf({`VAD_FLOOR_E, `VAD_FLOOR_M});
        for (int i = 1; i <= 8; i++) begin
            frame({32'h0014_4000, 32'h0010_4000}, 1, 0, 60, 90);
            if (i == 7)
                check("early", fac, {128'h0, 16'h0006});
        end
        check("ac load", fac, apa);
        bus(0, `VAD_OFS_THRESH, 0);
        t1 = pf(q);
        check("fall", t1 < t0 && t1 > t0 * 0.96, 1'b1);
        check("mant", q[15:14] != 2'b00, 1'b1);
        frame({32'h0014_4000, 32'h0015_4000}, 1, 1, 60, 90);
        bus(0, `VAD_OFS_THRESH, 0);
        check("rise", pf(q) > t1 * 1.05 && pf(q) < t1 * 1.07, 1'b1);
        check("mant", q[15:14] != 2'b00, 1'b1);
        bus(0, `VAD_OFS_FRAMES, 0);
        check("frames", q, 32'd68);
        wrap_up();
    end
endmodule : tb
